//--- smrc_map.svh
// register map, field positions, reset values and timing counts of the stop recovery block
// How it works
// - read-only stop flag: 0 after reset, 1 after recovery
// - control register at 0Bh; only bit 7 readable
// - bit 6 wake level, bit 5 delay enable
// - three-bit source picks pin, pin or NOR group
// - source field cleared on full reset
// - bit 1 divide-by-2 off, bit 0 extra divide-by-16
// - extension source: AND of low or all port-2 pins
// - extension register at 0Dh, write-only, upper bits reserved
// - watchdog mode at 0Fh, write-only, low bits reset 01101
// - registers live in bank Fh via pointer low nibble
// - only full reset initialises; stop recovery keeps values
`ifndef SMRC_MAP_SVH
`define SMRC_MAP_SVH
`define SMRC_BANK 4'hF
`define SMRC_OFS_CTRL 8'h0B
`define SMRC_OFS_EXT 8'h0D
`define SMRC_OFS_WDOG 8'h0F
`define SMRC_CTRL_RESET 8'h20
`define SMRC_EXT_RESET 2'h0
`define SMRC_WDOG_RESET 5'h0D
`define SMRC_BIT_FLAG 7
`define SMRC_BIT_LEVEL 6
`define SMRC_BIT_DELAY 5
`define SMRC_SRC_HI 4
`define SMRC_SRC_LO 2
`define SMRC_BIT_NODIV2 1
`define SMRC_BIT_DIV16 0
`define SMRC_DELAY_NS 5000
`define SMRC_CLK_NS 4
`define SMRC_DELAY_CYC ((`SMRC_DELAY_NS + `SMRC_CLK_NS - 1) / `SMRC_CLK_NS)
`endif

//--- smrc_pkg.sv
// types of the stop recovery block
package smrc_pkg;
    typedef enum logic [1:0] {
        SMRC_RUN = 2'h0,
        SMRC_STOP = 2'h1,
        SMRC_DELAY = 2'h3
    } smrc_state_type;
endpackage

//--- smrc_wake_select.sv
// wake condition selector over port pins
`timescale 1ns/1ps
module smrc_wake_select
(
    input wire logic [2:0] src_in,
    input wire logic [1:0] src_ext_in,
    input wire logic level_in,
    input wire logic [3:0] port3_in,
    input wire logic [7:0] port2_in,
    output logic wake_out
);
    logic primary;
    logic secondary;
    // primary source multiplexer, single pins with selected polarity, NOR groups without
    always_comb
    begin
        unique case (src_in)
            3'h0: primary = 1'b0;
            3'h1: primary = (port3_in[0] == level_in);
            3'h2: primary = (port3_in[1] == level_in);
            3'h3: primary = (port3_in[2] == level_in);
            3'h4: primary = (port3_in[3] == level_in);
            3'h5: primary = (port2_in[7] == level_in);
            3'h6: primary = ~|port2_in[3:0];
            default: primary = ~|port2_in;
        endcase
    end
    // extension source, reserved code never wakes
    always_comb
    begin
        unique case (src_ext_in)
            2'h1: secondary = &port2_in[3:0];
            2'h2: secondary = &port2_in;
            default: secondary = 1'b0;
        endcase
    end
    // both selections are mutually exclusive by software convention
    assign wake_out = primary | secondary;
endmodule

//--- smrc_clock_div.sv
// system and timer tick prescaler enable generator
`timescale 1ns/1ps
module smrc_clock_div
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic run_in,
    input wire logic nodiv2_in,
    input wire logic div16_in,
    output logic tick_out
);
    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } smrc_div_regs_type;

    smrc_div_regs_type r;
    smrc_div_regs_type next_r;
    logic [4:0] limit;
    // divide ratio: 1 or 2, times 16 when enabled
    always_comb
    begin
        limit = 5'h00;
        unique case ({div16_in, nodiv2_in})
            2'b00: limit = 5'h01;
            2'b01: limit = 5'h00;
            2'b10: limit = 5'h1F;
            default: limit = 5'h0F;
        endcase
    end
    // count crystal cycles, pulse once per divided period
    always_comb
    begin
        next_r = r;
        if (!run_in || r.cnt >= limit)
            next_r.cnt = 5'h00;
        else
            next_r.cnt = r.cnt + 5'h01;
        next_r.tick = run_in && (r.cnt >= limit);
    end
    // state held while the clock enable is low
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            r <= '0;
        else if (clk_en_in)
            r <= next_r;
    end
    assign tick_out = r.tick;
endmodule

//--- smrc_top.sv
// stop recovery control and clock prescale top
`timescale 1ns/1ps
`include "smrc_map.svh"
module smrc_top
#(
    parameter int DELAY_CYC = `SMRC_DELAY_CYC
)
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic [3:0] register_pointer_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic stop_req_in,
    input wire logic [3:0] port3_in,
    input wire logic [7:0] port2_in,
    output logic [7:0] reg_rdata_out,
    output logic stopped_out,
    output logic timer_tick_clock_out,
    output logic [4:0] watchdog_mode_out
);
    // refuse a recovery delay the sequencer cannot count
    if (DELAY_CYC < 1)
    begin : g_bad_delay
        $error("delay must be at least one cycle");
    end

    //****************************************
    // state
    //****************************************
    typedef struct packed {
        smrc_pkg::smrc_state_type st;
        logic flag;
        logic level;
        logic delay_en;
        logic [2:0] src;
        logic nodiv2;
        logic div16;
        logic [1:0] src_ext;
        logic [4:0] wdog;
        logic [31:0] cnt;
        logic [7:0] rdata;
        logic tick;
        logic stopped;
    } smrc_regs_type;

    smrc_regs_type r;
    smrc_regs_type next_r;
    logic wake;
    logic tick_raw;
    logic bank_sel;
    // last count of the recovery delay, used by the checks below
    localparam logic [31:0] DELAY_LAST = 32'(DELAY_CYC - 1);

    smrc_wake_select u_wake
    (
        .src_in(r.src),
        .src_ext_in(r.src_ext),
        .level_in(r.level),
        .port3_in(port3_in),
        .port2_in(port2_in),
        .wake_out(wake)
    );

    smrc_clock_div u_div
    (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .run_in(r.st == smrc_pkg::SMRC_RUN),
        .nodiv2_in(r.nodiv2),
        .div16_in(r.div16),
        .tick_out(tick_raw)
    );

    // bank Fh decode through the pointer low nibble
    assign bank_sel = (register_pointer_in == `SMRC_BANK);

    //****************************************
    // next state
    //****************************************
    // register writes, read mux and stop sequencer
    always_comb
    begin
        next_r = r;
        next_r.tick = tick_raw;
        next_r.rdata = 8'h00;
        if (bank_sel && reg_rd_in && reg_addr_in == `SMRC_OFS_CTRL)
            next_r.rdata = {r.flag, 7'h00};
        if (bank_sel && reg_wr_in)
        begin
            unique case (reg_addr_in)
                `SMRC_OFS_CTRL:
                begin
                    next_r.level = reg_wdata_in[`SMRC_BIT_LEVEL];
                    next_r.delay_en = reg_wdata_in[`SMRC_BIT_DELAY];
                    next_r.src = reg_wdata_in[`SMRC_SRC_HI:`SMRC_SRC_LO];
                    next_r.nodiv2 = reg_wdata_in[`SMRC_BIT_NODIV2];
                    next_r.div16 = reg_wdata_in[`SMRC_BIT_DIV16];
                end
                `SMRC_OFS_EXT: next_r.src_ext = reg_wdata_in[1:0];
                `SMRC_OFS_WDOG: next_r.wdog = reg_wdata_in[4:0];
                default: next_r.src = r.src;
            endcase
        end
        // registers stay untouched through recovery
        unique case (r.st)
            smrc_pkg::SMRC_RUN:
                if (stop_req_in)
                    next_r.st = smrc_pkg::SMRC_STOP;
            smrc_pkg::SMRC_STOP:
                if (wake)
                begin
                    next_r.cnt = 32'h0;
                    if (r.delay_en)
                        next_r.st = smrc_pkg::SMRC_DELAY;
                    else
                    begin
                        next_r.st = smrc_pkg::SMRC_RUN;
                        next_r.flag = 1'b1;
                    end
                end
            smrc_pkg::SMRC_DELAY:
                if (r.cnt >= 32'(DELAY_CYC - 1))
                begin
                    next_r.st = smrc_pkg::SMRC_RUN;
                    next_r.flag = 1'b1;
                end
                else
                    next_r.cnt = r.cnt + 32'h1;
            default: next_r.st = smrc_pkg::SMRC_RUN;
        endcase
        // status output registered from the next state
        next_r.stopped = (next_r.st != smrc_pkg::SMRC_RUN);
    end

    //****************************************
    // registers
    //****************************************
    // full reset initialises everything
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r.st <= smrc_pkg::SMRC_RUN;
            r.flag <= 1'b0;
            r.level <= 1'b0;
            r.delay_en <= 1'b1;
            r.src <= 3'h0;
            r.nodiv2 <= 1'b0;
            r.div16 <= 1'b0;
            r.src_ext <= `SMRC_EXT_RESET;
            r.wdog <= `SMRC_WDOG_RESET;
            r.cnt <= 32'h0;
            r.rdata <= 8'h00;
            r.tick <= 1'b0;
            r.stopped <= 1'b0;
        end
        else if (clk_en_in)
            r <= next_r;
    end

    assign reg_rdata_out = r.rdata;
    assign stopped_out = r.stopped;
    assign timer_tick_clock_out = r.tick;
    assign watchdog_mode_out = r.wdog;

    //****************************************
    // assertions
    //****************************************
    sequence s_wake_nodelay;
        r.st == smrc_pkg::SMRC_STOP && wake && !r.delay_en && clk_en_in;
    endsequence
    property p_flag_on_wake;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_wake_nodelay |=> (r.flag && r.st == smrc_pkg::SMRC_RUN);
    endproperty
    a_flag_on_wake: assert property (p_flag_on_wake) else $error("flag not set on wake");
    property p_flag_sticky;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        r.flag |=> r.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("stop flag cleared");
    property p_read_flag;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && bank_sel && reg_rd_in && reg_addr_in == `SMRC_OFS_CTRL)
            |=> reg_rdata_out == {$past(r.flag), 7'h00};
    endproperty
    a_read_flag: assert property (p_read_flag) else $error("bad control read");
    property p_write_ctrl;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && bank_sel && reg_wr_in && reg_addr_in == `SMRC_OFS_CTRL)
            |=> r.src == $past(reg_wdata_in[4:2]) && r.delay_en == $past(reg_wdata_in[5]);
    endproperty
    a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost");
    property p_write_ext;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && bank_sel && reg_wr_in && reg_addr_in == `SMRC_OFS_EXT)
            |=> r.src_ext == $past(reg_wdata_in[1:0]);
    endproperty
    a_write_ext: assert property (p_write_ext) else $error("ext write lost");
    property p_wdog_write;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && bank_sel && reg_wr_in && reg_addr_in == `SMRC_OFS_WDOG)
            |=> watchdog_mode_out == $past(reg_wdata_in[4:0]);
    endproperty
    a_wdog_write: assert property (p_wdog_write) else $error("watchdog write lost");
    property p_other_bank;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (!bank_sel && !stopped_out) |=> $stable(r.src) && $stable(r.src_ext);
    endproperty
    a_other_bank: assert property (p_other_bank) else $error("write outside bank");
    property p_delay_holds;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (r.st == smrc_pkg::SMRC_STOP && wake && r.delay_en && clk_en_in)
            |=> r.st == smrc_pkg::SMRC_DELAY && !$changed(r.level);
    endproperty
    a_delay_holds: assert property (p_delay_holds) else $error("delay skipped");
    property p_src_reset;
        @(posedge sys_clk_in) $rose(reset_n_in) |-> r.src == 3'h0;
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("source not cleared");

    // write-only registers and idle cycles read back as zero
    property p_read_ext;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && bank_sel && reg_rd_in && reg_addr_in == `SMRC_OFS_EXT)
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_read_ext: assert property (p_read_ext) else $error("ext register readable");
    property p_read_wdog;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && bank_sel && reg_rd_in && reg_addr_in == `SMRC_OFS_WDOG)
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_read_wdog: assert property (p_read_wdog) else $error("watchdog readable");
    property p_idle_read;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && !reg_rd_in) |=> reg_rdata_out == 8'h00;
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data without read");
    // level and divide bits land with the control write
    property p_write_div;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && bank_sel && reg_wr_in && reg_addr_in == `SMRC_OFS_CTRL)
            |=> r.nodiv2 == $past(reg_wdata_in[1]) && r.div16 == $past(reg_wdata_in[0])
            && r.level == $past(reg_wdata_in[6]);
    endproperty
    a_write_div: assert property (p_write_div) else $error("divide bits lost");

    // stop sequencing: entry, waiting, delay count and exit
    property p_enter_stop;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && r.st == smrc_pkg::SMRC_RUN && stop_req_in) |=> stopped_out;
    endproperty
    a_enter_stop: assert property (p_enter_stop) else $error("stop not entered");
    property p_stop_waits;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && r.st == smrc_pkg::SMRC_STOP && !wake) |=> r.st == smrc_pkg::SMRC_STOP;
    endproperty
    a_stop_waits: assert property (p_stop_waits) else $error("left stop without wake");
    property p_reserved_ext;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && r.st == smrc_pkg::SMRC_STOP && r.src == 3'h0 && r.src_ext == 2'h3)
            |=> r.st == smrc_pkg::SMRC_STOP;
    endproperty
    a_reserved_ext: assert property (p_reserved_ext) else $error("reserved code woke");
    property p_delay_count;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && r.st == smrc_pkg::SMRC_DELAY && r.cnt < DELAY_LAST)
            |=> r.st == smrc_pkg::SMRC_DELAY && r.cnt == $past(r.cnt) + 32'h1;
    endproperty
    a_delay_count: assert property (p_delay_count) else $error("delay cut short");
    property p_delay_exit;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && r.st == smrc_pkg::SMRC_DELAY && r.cnt >= DELAY_LAST) |=> !stopped_out && r.flag;
    endproperty
    a_delay_exit: assert property (p_delay_exit) else $error("delay did not end");

    // clock enable low freezes every register
    property p_freeze;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        !clk_en_in |=> $stable(r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    // prescaler: silent while stopped, every cycle when undivided
    sequence s_halted_two;
        (clk_en_in && r.st != smrc_pkg::SMRC_RUN) ##1 (clk_en_in && r.st != smrc_pkg::SMRC_RUN);
    endsequence
    property p_tick_halts;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_halted_two |=> !timer_tick_clock_out;
    endproperty
    a_tick_halts: assert property (p_tick_halts) else $error("tick while stopped");
    sequence s_fast_two;
        (clk_en_in && r.st == smrc_pkg::SMRC_RUN && r.nodiv2 && !r.div16)
            ##1 (clk_en_in && r.st == smrc_pkg::SMRC_RUN && r.nodiv2 && !r.div16);
    endsequence
    property p_tick_fast;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_fast_two |=> timer_tick_clock_out;
    endproperty
    a_tick_fast: assert property (p_tick_fast) else $error("undivided tick missing");
endmodule

//--- smrc_testbench.sv
// self-checking testbench of the stop recovery control block
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // signals and design instance
    // ****************************************
    localparam int DC = 4;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] ptr = 4'hF;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic stop_req = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] p3 = 4'h0;
    logic [7:0] p2 = 8'h00;
    logic [7:0] rdata;
    logic stopped;
    logic tick;
    logic [4:0] wdog;
    int err_count = 0;
    int total_checks = 0;
    int n;
    // wake table: control, extension, idle pins, wake pins; latency bounds are passed by the caller
    logic [7:0] t_c [10] = '{8'h04, 8'h48, 8'h0C, 8'h50, 8'h54, 8'h18, 8'h1C, 8'h00, 8'h00, 8'h24};
    logic [1:0] t_e [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    logic [3:0] t_i3 [10] = '{4'hF, 4'h0, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hF};
    logic [7:0] t_i2 [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h80, 8'h07, 8'h7F, 8'h00};
    logic [3:0] t_w3 [10] = '{4'hE, 4'h2, 4'hB, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hE};
    logic [7:0] t_w2 [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'hF0, 8'h00, 8'h0F, 8'hFF, 8'h00};
    logic [7:0] t_div [4] = '{8'h20, 8'h22, 8'h23, 8'h21};
    logic [7:0] t_tk [4] = '{8'h10, 8'h20, 8'h02, 8'h01};

    smrc_top #(.DELAY_CYC(DC)) dut_u (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
        .clk_en_in(clk_en), .register_pointer_in(ptr), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .stop_req_in(stop_req), .port3_in(p3),
        .port2_in(p2), .reg_rdata_out(rdata), .stopped_out(stopped),
        .timer_tick_clock_out(tick), .watchdog_mode_out(wdog));

    // ****************************************
    // clock, watchdog and verdict
    // ****************************************
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        #100000;
        err_count++;
        finish_test();
    end

    task automatic finish_test();
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************
    // access tasks
    // ****************************************
    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic wr_reg(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        ptr = b;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
        ptr = 4'hF;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] b, input logic [7:0] a,
        input logic [7:0] exp);
        @(negedge sys_clk);
        ptr = b;
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk);
        rd = 1'b0;
        ptr = 4'hF;
        cmp(name, exp, rdata);
    endtask

    // counts tick pulses over a fixed window
    task automatic count_ticks(input int ncyc, output int cnt);
        cnt = 0;
        repeat (ncyc)
        begin
            @(negedge sys_clk);
            if (tick === 1'b1)
                cnt++;
        end
    endtask

    task automatic enter_stop();
        @(negedge sys_clk);
        stop_req = 1'b1;
        @(negedge sys_clk);
        stop_req = 1'b0;
        repeat (3) @(negedge sys_clk);
        cmp("stopped", 8'h01, {7'h0, stopped});
    endtask

    // one stop and wake pass through a table row
    task automatic stop_row(input int i, input int lo, input int hi);
        int k;
        k = 0;
        wr_reg(4'hF, 8'h0D, 8'h00);
        wr_reg(4'hF, 8'h0B, t_c[i]);
        wr_reg(4'hF, 8'h0D, {6'h00, t_e[i]});
        p3 = t_i3[i];
        p2 = t_i2[i];
        enter_stop();
        p3 = t_w3[i];
        p2 = t_w2[i];
        while (stopped === 1'b1 && k < 40)
        begin
            @(negedge sys_clk);
            k++;
        end
        cmp("wake_latency", 8'h01, {7'h0, (k >= lo && k <= hi)});
        rd_chk("stop_flag", 4'hF, 8'h0B, 8'h80);
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        cmp("wdog_reset", 8'h0D, {3'h0, wdog});
        cmp("stopped_reset", 8'h00, {7'h0, stopped});
        rd_chk("ctrl_read", 4'hF, 8'h0B, 8'h00);
        rd_chk("ext_read", 4'hF, 8'h0D, 8'h00);
        rd_chk("wdog_read", 4'hF, 8'h0F, 8'h00);
        wr_reg(4'h0, 8'h0F, 8'h12);
        cmp("wdog_bank", 8'h0D, {3'h0, wdog});
        wr_reg(4'hF, 8'h0F, 8'hF2);
        cmp("wdog_write", 8'h12, {3'h0, wdog});
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(4'hF, 8'h0B, t_div[i]);
            count_ticks(32, n);
            cmp("tick_count", t_tk[i], n[7:0]);
        end
        for (int i = 0; i < 10; i++)
            stop_row(i, (i == 9) ? DC + 1 : 1, (i == 9) ? DC + 3 : 3);
        wr_reg(4'hF, 8'h0B, 8'h04);
        p3 = 4'hF;
        enter_stop();
        clk_en = 1'b0;
        p3 = 4'hE;
        repeat (4) @(negedge sys_clk);
        cmp("frozen", 8'h01, {7'h0, stopped});
        clk_en = 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp("thawed", 8'h00, {7'h0, stopped});
        rd_chk("ctrl_bank", 4'h0, 8'h0B, 8'h00);
        cmp("wdog_kept", 8'h12, {3'h0, wdog});
        wr_reg(4'hF, 8'h0B, 8'h00);
        wr_reg(4'hF, 8'h0D, 8'h03);
        enter_stop();
        p3 = 4'hF;
        p2 = 8'hFF;
        repeat (4) @(negedge sys_clk);
        p3 = 4'h0;
        p2 = 8'h00;
        repeat (4) @(negedge sys_clk);
        cmp("no_wake", 8'h01, {7'h0, stopped});
        wr_reg(4'hF, 8'h0D, 8'h00);
        wr_reg(4'hF, 8'h0B, 8'h44);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        rd_chk("flag_por", 4'hF, 8'h0B, 8'h00);
        cmp("wdog_por", 8'h0D, {3'h0, wdog});
        count_ticks(32, n);
        cmp("tick_por", 8'h10, n[7:0]);
        enter_stop();
        repeat (4) @(negedge sys_clk);
        cmp("src_por", 8'h01, {7'h0, stopped});
        finish_test();
    end
endmodule
